// file: core/icap_cfg.svh
// Register map, field positions, reset values and counts of the input capture unit
`ifndef ICAP_CFG_SVH
`define ICAP_CFG_SVH

// Register byte offsets (decoded on haddr[7:0])
`define ICAP_CTRL_OFFSET     8'h00
`define ICAP_STATUS_OFFSET   8'h04
`define ICAP_BUF_OFFSET      8'h08

// Control register layout, bits [9:0]
`define ICAP_CTRL_MSB        9
`define ICAP_CTRL_RESET      10'h000

// Status register layout
`define ICAP_STAT_NEMPTY_BIT 0
`define ICAP_STAT_OVF_BIT    1
`define ICAP_STAT_CNT_LSB    2

// Prescaler terminal counts (edge four and edge sixteen)
`define ICAP_DIV4_LAST       4'h3
`define ICAP_DIV16_LAST      4'hf

`endif

// file: core/icap_pkg.sv
// Types shared by the input capture unit
package icap_pkg;

    // Capture event modes, written in ctrl[2:0]
    typedef enum logic [2:0] {
        mode_off,
        mode_every_edge,
        mode_falling,
        mode_rising,
        mode_div4,
        mode_div16,
        mode_edge_first,
        mode_irq_only
    } mode_type;

    // Control register, packed to match its bit layout [9:0]
    typedef struct packed {
        logic       irq_en;        // [9]
        logic       enable;        // [8]
        logic [1:0] irq_count;     // [7:6] entries minus one
        logic       first_rising;  // [5]
        logic       wide;          // [4]
        logic       tsel;          // [3]
        mode_type   mode;          // [2:0]
    } ctrl_type;

    // State of the capture unit outside the capture buffer
    typedef struct packed {
        ctrl_type    ctrl;
        logic        pin_prev;
        logic        primed;
        logic        first_done;
        logic [3:0]  presc;
        logic        overflow;
        logic        wr_pend;
        logic [7:0]  addr;
        logic [31:0] hrdata;
        logic        irq;
        logic        wake;
    } state_type;

endpackage

// file: core/capture_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module capture_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int CNT_W = $clog2(DEPTH + 1),
    parameter int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic [CNT_W-1:0]      o_count
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [CNT_W-1:0]            count;
    } fifo_state_type;

    fifo_state_type s_reg;
    fifo_state_type s_next;
    logic           push;
    logic           pop;

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes come straight from the count so full and empty are exact
    assign o_in_ready  = (s_reg.count != CNT_W'(DEPTH));
    assign o_out_valid = (s_reg.count != '0);
    assign o_out_data  = s_reg.mem[s_reg.rd_ptr];
    assign o_count     = s_reg.count;
    assign push        = i_in_valid & o_in_ready;
    assign pop         = i_out_ready & o_out_valid;

    // Pointer wrap handled explicitly so a depth off a power of two still works
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr_ptr] = i_in_data;
            s_next.wr_ptr = (s_reg.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_next.rd_ptr = (s_reg.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            s_next.count = s_reg.count + 1'b1;
        end else if (pop && !push) begin
            s_next.count = s_reg.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule // capture_fifo

// file: core/input_capture_unit.sv
// Input capture channel with edge modes, prescaler, capture buffer and AHB-Lite registers
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "icap_cfg.svh"

// Behaviour
// RL1: On a selected pin event, record the chosen timer base, 16 or 32 bits.
// RL2: Falling-edge mode captures on every high-to-low pin transition.
// RL3: Rising-edge mode captures on every low-to-high pin transition.
// RL4: Every-edge mode captures on both rising and falling transitions.
// RL5: Edge-first mode waits for the configured polarity, then captures every edge.
// RL6: Divide-by-four mode captures only on each fourth rising edge.
// RL7: Divide-by-sixteen mode captures only on each sixteenth rising edge.
// RL8: Capture source selectable between the first and second 16-bit timebases.
// RL9: Both timebases may join as one 32-bit count for capture.
// RL10: Captured values are held in a four-word first-in first-out buffer.
// RL11: The channel can raise an interrupt on a capture event.
// RL12: Enabled interrupt fires when the buffer reaches one to four entries.
// RL13: A pin event can wake the processor from Sleep or Idle.
// RL14: The channel can act purely as an edge-triggered interrupt source.
// RL15: Buffer reads return and remove the oldest value; not-empty tracks count.
// RL16: A capture with all entries full is dropped and sets overflow.
module input_capture_unit
    import icap_pkg::*;
#(
    parameter int FIFO_DEPTH = 4,
    parameter int CNT_W      = $clog2(FIFO_DEPTH + 1)
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,

    // Register bus slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,

    // Capture pin and timebases
    input  wire logic        i_capture_input_pin,
    input  wire logic [15:0] i_first_timebase,
    input  wire logic [15:0] i_second_timebase,

    // Processor low-power state
    input  wire logic        i_cpu_sleep,
    input  wire logic        i_cpu_idle,

    // Interrupt, wake and status
    output logic             o_capture_irq,
    output logic             o_wake,
    output logic             o_buf_not_empty,
    output logic             o_overflow
);

    state_type         s_reg;
    state_type         s_next;

    // Edge and event qualification
    logic              pin_rise;
    logic              pin_fall;
    logic              hit;
    logic              store;

    // Bus decode
    logic              addr_ok;
    logic              take;

    // Buffer handshake and data
    logic              pop;
    logic              push_ready;
    logic              out_valid;
    logic [31:0]       push_data;
    logic [31:0]       pop_data;
    logic [CNT_W-1:0]  fifo_count;
    logic [CNT_W-1:0]  level_after;

    // Status read back
    logic [31:0]       status_word;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake and outputs
    // A read arriving over a pending write waits a cycle, so it sees the new value
    // Ready ignores i_hready, which is this output fed back: no combinational loop
    assign addr_ok     = i_hsel & i_htrans[1] & i_hready;
    assign o_hreadyout = ~(s_reg.wr_pend & i_hsel & i_htrans[1] & ~i_hwrite);
    assign take        = addr_ok & o_hreadyout;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = s_reg.hrdata;
    assign o_capture_irq = s_reg.irq;
    assign o_wake      = s_reg.wake;
    assign o_overflow  = s_reg.overflow;
    // RL15 not-empty flag
    assign o_buf_not_empty = out_valid;

    // Edge detection; no edge is seen until the first sample after reset
    assign pin_rise = s_reg.primed & i_capture_input_pin & ~s_reg.pin_prev;
    assign pin_fall = s_reg.primed & ~i_capture_input_pin & s_reg.pin_prev;

    // RL1 timer value select
    // RL8 timebase choice
    // RL9 joined 32-bit count
    assign push_data = s_reg.ctrl.wide ? {i_second_timebase, i_first_timebase} :
                       s_reg.ctrl.tsel ? {16'h0000, i_second_timebase} :
                                         {16'h0000, i_first_timebase};

    // Interrupt-only mode detects edges but never fills the buffer
    // RL14 interrupt-only source
    assign store = hit & (s_reg.ctrl.mode != mode_irq_only);

    // Buffer pops on a taken read of the buffer register
    assign pop = take & ~i_hwrite & (i_haddr[7:0] == `ICAP_BUF_OFFSET) & out_valid;

    // Entry count after this cycle's push and pop
    assign level_after = fifo_count + CNT_W'(store & push_ready) - CNT_W'(pop);

    // Count sits above the not-empty and overflow bits
    assign status_word = {{(32 - `ICAP_STAT_CNT_LSB - CNT_W){1'b0}}, fifo_count,
                          s_reg.overflow, out_valid};

    // RL10 four-word buffer
    capture_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH)
    ) u_capture_fifo (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (store),
        .o_in_ready  (push_ready),
        .i_in_data   (push_data),
        .o_out_valid (out_valid),
        .i_out_ready (pop),
        .o_out_data  (pop_data),
        .o_count     (fifo_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event selection, bus writes and flags
    always_comb begin
        s_next          = s_reg;
        hit             = 1'b0;
        s_next.irq      = 1'b0;
        s_next.wake     = 1'b0;
        // Last pin sample; primed holds off a false edge after reset
        s_next.pin_prev = i_capture_input_pin;
        s_next.primed   = 1'b1;

        // Data phase of a write; ctrl write restarts prescaler and first-edge wait
        if (s_reg.wr_pend) begin
            if (s_reg.addr == `ICAP_CTRL_OFFSET) begin
                s_next.ctrl       = ctrl_type'(i_hwdata[`ICAP_CTRL_MSB:0]);
                s_next.presc      = 4'h0;
                s_next.first_done = 1'b0;
            end else if (s_reg.addr == `ICAP_STATUS_OFFSET) begin
                if (i_hwdata[`ICAP_STAT_OVF_BIT]) begin
                    s_next.overflow = 1'b0;
                end
            end
        end

        // Edge qualification by mode
        if (s_reg.ctrl.enable) begin
            case (s_reg.ctrl.mode)
                // RL2 falling edges
                mode_falling: begin
                    hit = pin_fall;
                end
                // RL3 rising edges
                mode_rising: begin
                    hit = pin_rise;
                end
                // RL4 both edges
                mode_every_edge, mode_irq_only: begin
                    hit = pin_rise | pin_fall;
                end
                // Polarity matters only until the first capture
                // RL5 chosen edge first
                mode_edge_first: begin
                    if (s_reg.first_done) begin
                        hit = pin_rise | pin_fall;
                    end else begin
                        hit = s_reg.ctrl.first_rising ? pin_rise : pin_fall;
                    end
                    if (hit) begin
                        s_next.first_done = 1'b1;
                    end
                end
                // Count restarts on each capture so the gap stays exact
                // RL6 every fourth rise
                mode_div4: begin
                    if (pin_rise) begin
                        hit = (s_reg.presc == `ICAP_DIV4_LAST);
                        s_next.presc = hit ? 4'h0 : s_reg.presc + 4'h1;
                    end
                end
                // RL7 every sixteenth rise
                mode_div16: begin
                    if (pin_rise) begin
                        hit = (s_reg.presc == `ICAP_DIV16_LAST);
                        s_next.presc = hit ? 4'h0 : s_reg.presc + 4'h1;
                    end
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end

        // RL16 overflow on full
        // Set after the clear so a coincident event is never lost
        if (store && !push_ready) begin
            s_next.overflow = 1'b1;
        end

        // RL11 capture interrupt
        // RL12 fill threshold
        if (s_reg.ctrl.irq_en) begin
            if (s_reg.ctrl.mode == mode_irq_only) begin
                s_next.irq = hit;
            end else begin
                s_next.irq = store & push_ready &
                             (level_after == CNT_W'(s_reg.ctrl.irq_count) + 1'b1);
            end
        end

        // RL13 wake from low power
        s_next.wake = hit & (i_cpu_sleep | i_cpu_idle);

        // Address phase: latch write target, or fetch read data now
        s_next.wr_pend = take & i_hwrite;
        if (take) begin
            s_next.addr = i_haddr[7:0];
        end
        if (take && !i_hwrite) begin
            case (i_haddr[7:0])
                `ICAP_CTRL_OFFSET:   s_next.hrdata = {22'h000000, s_reg.ctrl};
                `ICAP_STATUS_OFFSET: s_next.hrdata = status_word;
                // RL15 oldest value
                `ICAP_BUF_OFFSET:    s_next.hrdata = out_valid ? pop_data : 32'h00000000;
                default:             s_next.hrdata = 32'h00000000;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_reg      <= '0;
            s_reg.ctrl <= ctrl_type'(`ICAP_CTRL_RESET);
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_fall_push: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL2
        s_reg.ctrl.enable && s_reg.ctrl.mode == mode_falling && pin_fall |-> store)
        else $error("falling edge not captured");

    a_rise_push: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL3
        s_reg.ctrl.enable && s_reg.ctrl.mode == mode_rising && (pin_rise != store) |-> 1'b0)
        else $error("rising mode capture mismatch");

    a_both_push: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL4
        s_reg.ctrl.enable && s_reg.ctrl.mode == mode_every_edge && s_reg.primed &&
        (i_capture_input_pin != s_reg.pin_prev) |-> store)
        else $error("edge missed in every-edge mode");

    a_first_edge: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL5
        s_reg.ctrl.mode == mode_edge_first && !s_reg.first_done && store |->
        (s_reg.ctrl.first_rising ? pin_rise : pin_fall) ##1 s_reg.first_done)
        else $error("wrong first edge captured");

    a_div4_gap: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL6
        s_reg.ctrl.mode == mode_div4 && store |-> pin_rise && s_reg.presc == 4'h3)
        else $error("div4 capture off count");

    a_div16_gap: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL7
        s_reg.ctrl.mode == mode_div16 && store |-> pin_rise && s_reg.presc == 4'hf)
        else $error("div16 capture off count");

    a_narrow_sel: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL8
        store && !s_reg.ctrl.wide |-> push_data == {16'h0000,
        (s_reg.ctrl.tsel ? i_second_timebase : i_first_timebase)})
        else $error("wrong timebase captured");

    a_wide_data: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL9
        store && s_reg.ctrl.wide |-> push_data == {i_second_timebase, i_first_timebase})
        else $error("32-bit capture malformed");

    a_ovf_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL16
        store && !push_ready |=> o_overflow && fifo_count == $past(level_after))
        else $error("overflow not flagged");

    a_irq_level: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL12
        store && push_ready && s_reg.ctrl.irq_en && s_reg.ctrl.mode != mode_irq_only &&
        level_after == CNT_W'(s_reg.ctrl.irq_count) + 1'b1 |=> o_capture_irq)
        else $error("threshold interrupt missing");

    a_wake_event: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL13
        hit && (i_cpu_sleep || i_cpu_idle) |=> o_wake)
        else $error("wake not raised");

    a_pop_order: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL15
        pop |=> o_hrdata == $past(pop_data) && fifo_count == $past(level_after))
        else $error("buffer read not oldest");

    // Interrupt, buffer, flag and prescaler checks
    a_irq_only: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL14
        s_reg.ctrl.mode == mode_irq_only && s_reg.ctrl.irq_en && hit |->
        !store ##1 o_capture_irq)
        else $error("edge interrupt missing");

    a_irq_mask: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL11
        !s_reg.ctrl.irq_en |=> !o_capture_irq)
        else $error("masked interrupt raised");

    a_push_level: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL10
        store && push_ready |=> fifo_count == $past(level_after) && fifo_count != '0)
        else $error("capture not buffered");

    a_ovf_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL16
        o_overflow && !(s_reg.wr_pend && s_reg.addr == `ICAP_STATUS_OFFSET &&
        i_hwdata[`ICAP_STAT_OVF_BIT]) |=> o_overflow)
        else $error("overflow flag lost");

    a_ovf_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL16
        s_reg.wr_pend && s_reg.addr == `ICAP_STATUS_OFFSET &&
        i_hwdata[`ICAP_STAT_OVF_BIT] && !(store && !push_ready) |=> !o_overflow)
        else $error("overflow not cleared");

    a_empty_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL15
        take && !i_hwrite && i_haddr[7:0] == `ICAP_BUF_OFFSET && !out_valid |=>
        o_hrdata == 32'h00000000)
        else $error("empty read not zero");

    a_presc_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL6
        s_reg.ctrl.enable && s_reg.ctrl.mode == mode_div4 && !pin_rise && !s_reg.wr_pend
        |=> $stable(s_reg.presc))
        else $error("prescaler moved without a rise");

endmodule // input_capture_unit

// file: test/pin_source.sv
// Far-side signal source that drives the capture input pin
`timescale 1ns/100ps
module pin_source (
    input  wire logic i_clk,
    output logic      o_pin
);
    // Pin rests low until the bench asks for another level
    initial begin
        o_pin = 1'b0;
    end

    // Level lands just after a rising edge, so the capture side sees it one edge later
    task automatic set_level(input logic level);
        @(posedge i_clk);
        o_pin <= level;
    endtask
endmodule // pin_source

// file: test/input_capture_unit_bench.sv
// Self-checking bench for the input capture unit over its bus and capture pin
`timescale 1ns/100ps
`include "icap_cfg.svh"
module input_capture_unit_bench
    import icap_pkg::*;
;
    logic        clk;
    logic        sys_rst;
    logic        hsel;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin;
    logic        cpu_sleep;
    logic        cpu_idle;
    logic        irq;
    logic        wake;
    logic        nempty;
    logic        ovf;
    logic [15:0] first_tb = 16'h1230;
    logic [15:0] second_tb = 16'hfff0;
    int          failures;
    int          checks;
    int          irq_seen = 0;
    int          wake_seen = 0;

    ////////////////////////////////////////////////////////////////////////////////
    input_capture_unit #(.FIFO_DEPTH(4)) u_input_capture_unit (
        .i_clk(clk), .i_sys_rst(sys_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_capture_input_pin(pin), .i_first_timebase(first_tb),
        .i_second_timebase(second_tb), .i_cpu_sleep(cpu_sleep), .i_cpu_idle(cpu_idle),
        .o_capture_irq(irq), .o_wake(wake), .o_buf_not_empty(nempty), .o_overflow(ovf)
    );
    pin_source u_pin_source (.i_clk(clk), .o_pin(pin));

    // Free clock
    always #10 clk = ~clk;

    // Timebases move every cycle so a capture at the wrong edge shows
    always @(posedge clk) begin
        first_tb  <= first_tb + 16'h0001;
        second_tb <= second_tb - 16'h0003;
    end

    // Count one-cycle pulses; an unknown counts too, so it cannot hide
    always @(posedge clk) begin
        if (irq !== 1'b0) irq_seen <= irq_seen + 1;
        if (wake !== 1'b0) wake_seen <= wake_seen + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ready and read data are sampled at the rising edge that ends the phase
    task automatic wait_rdy(output logic [31:0] d);
        int   n;
        logic r;
        n = 0;
        r = 1'b0;
        while (!r) begin
            @(posedge clk);
            r = (hreadyout === 1'b1);
            d = hrdata;
            n++;
            if (n > 50) begin
                failures++;
                stop_test();
            end
        end
    endtask

    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd_data);
        logic [31:0] unused;
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        hsize  <= 3'b010;
        wait_rdy(unused);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(rd_data);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, a, wd, d);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Configure, toggle the pin with a reference model alongside, then drain
    task automatic run(input mode_type m, input logic tsel, input logic wide, input logic fr,
                       input logic [1:0] ic, input logic en, input logic ie, input int pulses,
                       input logic slp, input logic idl);
        ctrl_type    c;
        logic [31:0] q[$];
        logic [31:0] d;
        logic        lvl;
        logic        cap;
        logic        armed;
        logic        ovf_exp;
        int          pc;
        int          eirq;
        int          ewake;
        int          st;
        int          irq_base;
        int          wake_base;
        c = '0;
        c.irq_en = ie;
        c.enable = en;
        c.irq_count = ic;
        c.first_rising = fr;
        c.wide = wide;
        c.tsel = tsel;
        c.mode = m;
        wr(`ICAP_CTRL_OFFSET, {22'h0, c});
        rd(`ICAP_CTRL_OFFSET, d);
        check(d, {22'h0, c});
        @(posedge clk);
        cpu_sleep <= slp;
        cpu_idle  <= idl;
        irq_base = irq_seen;
        wake_base = wake_seen;
        lvl = 1'b0;
        armed = 1'b0;
        ovf_exp = 1'b0;
        pc = 0;
        eirq = 0;
        ewake = 0;
        for (int i = 0; i < 2 * pulses; i++) begin
            lvl = ~lvl;
            u_pin_source.set_level(lvl);
            #1;
            case (m)
                mode_every_edge: cap = 1'b1;
                mode_falling:    cap = ~lvl;
                mode_rising:     cap = lvl;
                mode_div4: begin
                    pc = pc + int'(lvl);
                    cap = lvl && (pc % 4 == 0);
                end
                mode_div16: begin
                    pc = pc + int'(lvl);
                    cap = lvl && (pc % 16 == 0);
                end
                mode_edge_first: begin
                    armed = armed | (lvl == fr);
                    cap = armed;
                end
                default: cap = 1'b0;
            endcase
            cap = cap & en;
            if (ie && en && m == mode_irq_only) eirq++;
            if (cap) begin
                ewake += int'(slp | idl);
                if (q.size() < 4) begin
                    q.push_back(wide ? {second_tb, first_tb} : {16'h0, tsel ? second_tb : first_tb});
                    if (ie && q.size() == int'(ic) + 1) eirq++;
                end else begin
                    ovf_exp = 1'b1;
                end
            end
            @(posedge clk);
        end
        repeat (6) @(posedge clk);
        cpu_sleep <= 1'b0;
        cpu_idle  <= 1'b0;
        check(irq_seen - irq_base, eirq);
        check(wake_seen - wake_base, ewake);
        st = q.size() * 4 + (ovf_exp ? 2 : 0) + (q.size() != 0 ? 1 : 0);
        rd(`ICAP_STATUS_OFFSET, d);
        check(d, 32'(st));
        check({31'h0, ovf}, {31'h0, ovf_exp});
        check({31'h0, nempty}, {31'h0, q.size() != 0});
        while (q.size() > 0) begin
            rd(`ICAP_BUF_OFFSET, d);
            check(d, q.pop_front());
        end
        rd(`ICAP_BUF_OFFSET, d);
        check(d, 32'h0);
        check({31'h0, nempty}, 32'h0);
        wr(`ICAP_STATUS_OFFSET, 32'h2);
        rd(`ICAP_STATUS_OFFSET, d);
        check(d, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d;
        clk = 1'b0;
        sys_rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        cpu_sleep = 1'b0;
        cpu_idle = 1'b0;
        failures = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset state, then an unmapped place that must read zero and ignore writes
        rd(`ICAP_CTRL_OFFSET, d);
        check(d, 32'h0);
        rd(`ICAP_STATUS_OFFSET, d);
        check(d, 32'h0);
        check({27'h0, irq, wake, nempty, ovf, hresp}, 32'h0);
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c, d);
        check(d, 32'h0);
        rd(`ICAP_CTRL_OFFSET, d);
        check(d, 32'h0);
        // Every mode, both timebases, joined width, thresholds one to four
        run(mode_every_edge, 1'b0, 1'b0, 1'b0, 2'd3, 1'b1, 1'b1, 2, 1'b0, 1'b1);
        run(mode_falling, 1'b1, 1'b0, 1'b0, 2'd1, 1'b1, 1'b1, 3, 1'b1, 1'b0);
        run(mode_rising, 1'b0, 1'b1, 1'b0, 2'd0, 1'b1, 1'b1, 5, 1'b0, 1'b0);
        run(mode_div4, 1'b0, 1'b0, 1'b0, 2'd0, 1'b1, 1'b1, 9, 1'b0, 1'b0);
        run(mode_div16, 1'b1, 1'b1, 1'b0, 2'd0, 1'b1, 1'b1, 17, 1'b0, 1'b0);
        run(mode_edge_first, 1'b0, 1'b0, 1'b1, 2'd2, 1'b1, 1'b1, 2, 1'b0, 1'b0);
        run(mode_edge_first, 1'b1, 1'b0, 1'b0, 2'd2, 1'b1, 1'b1, 2, 1'b0, 1'b0);
        run(mode_irq_only, 1'b0, 1'b0, 1'b0, 2'd0, 1'b1, 1'b1, 2, 1'b0, 1'b0);
        run(mode_rising, 1'b0, 1'b0, 1'b0, 2'd0, 1'b0, 1'b1, 2, 1'b1, 1'b0);
        run(mode_rising, 1'b1, 1'b0, 1'b0, 2'd0, 1'b1, 1'b0, 2, 1'b0, 1'b0);
        run(mode_off, 1'b0, 1'b0, 1'b0, 2'd0, 1'b1, 1'b1, 2, 1'b0, 1'b0);
        stop_test();
    end
endmodule // input_capture_unit_bench
